// [verilog/watchdog_ctrl_regs.vh]
`ifndef WATCHDOG_CTRL_REGS_VH
`define WATCHDOG_CTRL_REGS_VH

// ----------------------------------------
// Register byte addresses (low address bits)
// ----------------------------------------
`define ADDR_W            4
`define ADDR_CONTROL      4'h0
`define ADDR_CORE_CTRL    4'h4
`define ADDR_INT_STATUS   4'h8
`define ADDR_INT_MASK     4'hc

// ----------------------------------------
// watchdog_control_status bit positions
// ----------------------------------------
`define BIT_IRQ_FLAG      7
`define BIT_IRQ_ENABLE    6
`define BIT_SEL3          5
`define BIT_GUARD         4
`define BIT_RST_ENABLE    3
`define BIT_SEL2          2
`define BIT_SEL1          1
`define BIT_SEL0          0

// ----------------------------------------
// core_ctrl bit positions
// ----------------------------------------
`define BIT_GIE           0
`define BIT_KICK          1
`define BIT_FUSE          2
`define BIT_RESET_FLAG    3

// ----------------------------------------
// Interrupt status / mask bit positions
// ----------------------------------------
`define EV_W              2
`define EV_TIMEOUT_IRQ    0
`define EV_RESET_REQ      1

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_SEL           4'h0
`define RST_EV            2'h0
`define GUARD_CYCLES      3'h4
`define GUARD_LAST        3'h1
`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2

`endif

// [verilog/period_divider.v]
`timescale 1ns/10ps
module period_divider #(
   parameter BASE_SHIFT = 4                    // Shortest period is 2**BASE_SHIFT cycles
) (
   input  wire       clk,                      // System clock
   input  wire       rst,                      // Synchronous reset, high
   input  wire       run,                      // Count while high
   input  wire       restart,                  // Restart the period
   input  wire [3:0] sel,                      // Period select
   output reg        timeout                   // One-cycle time-out pulse
);

localparam CNT_W = BASE_SHIFT + 16;

reg  [CNT_W-1:0] count_reg;
wire [CNT_W-1:0] tap_mask;
wire             at_tap;

// Period is 2**(BASE_SHIFT + sel) cycles
assign tap_mask = ({{(CNT_W-1){1'b0}}, 1'b1} << (BASE_SHIFT + sel)) - {{(CNT_W-1){1'b0}}, 1'b1};
assign at_tap   = ((count_reg & tap_mask) == tap_mask);

always @(posedge clk) begin
   if (rst) begin
      count_reg <= {CNT_W{1'b0}};
      timeout   <= 1'b0;
   end else if (!run || restart) begin
      count_reg <= {CNT_W{1'b0}};
      timeout   <= 1'b0;
   end else if (at_tap) begin
      count_reg <= {CNT_W{1'b0}};
      timeout   <= 1'b1;
   end else begin
      count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
      timeout   <= 1'b0;
   end
end

endmodule // period_divider

// [verilog/watchdog_control_modes.v]
`timescale 1ns/10ps
`include "watchdog_ctrl_regs.vh"

module watchdog_control_modes #(
   parameter BASE_SHIFT = 4                          // Shortest time-out is 2**BASE_SHIFT cycles
) (
   input  wire                clk,                   // System clock, 40 MHz
   input  wire                rst,                   // Synchronous reset, high
   input  wire [`ADDR_W-1:0]  s_axi_awaddr,          // Write address
   input  wire                s_axi_awvalid,         // Write address valid
   output reg                 s_axi_awready,         // Write address ready
   input  wire [31:0]         s_axi_wdata,           // Write data
   input  wire [3:0]          s_axi_wstrb,           // Write strobes
   input  wire                s_axi_wvalid,          // Write data valid
   output reg                 s_axi_wready,          // Write data ready
   output reg  [1:0]          s_axi_bresp,           // Write response
   output reg                 s_axi_bvalid,          // Write response valid
   input  wire                s_axi_bready,          // Write response ready
   input  wire [`ADDR_W-1:0]  s_axi_araddr,          // Read address
   input  wire                s_axi_arvalid,         // Read address valid
   output reg                 s_axi_arready,         // Read address ready
   output reg  [31:0]         s_axi_rdata,           // Read data
   output reg  [1:0]          s_axi_rresp,           // Read response
   output reg                 s_axi_rvalid,          // Read data valid
   input  wire                s_axi_rready,          // Read data ready
   input  wire                always_on_fuse,        // Fuse strap pin
   input  wire                watchdog_reset_flag,   // Reset-cause flag from reset logic
   input  wire                vector_exec,           // Core executes watchdog vector, pulse
   input  wire                irq_taken,             // Core takes any interrupt, pulse
   input  wire                irq_return,            // Core returns from interrupt, pulse
   output reg                 wdt_irq_req,           // Watchdog interrupt request to core
   output reg                 sys_reset_req,         // System reset request, pulse
   output reg                 global_irq_enable,     // Global interrupt enable
   output reg                 irq                    // Bus-side interrupt, level
);

// ----------------------------------------
// State
// ----------------------------------------
reg              irq_flag_reg;
reg              irq_enable_reg;
reg              guard_reg;
reg  [2:0]       guard_cnt_reg;
reg              rst_enable_reg;
reg  [3:0]       sel_reg;
reg  [`EV_W-1:0] ev_status_reg;
reg  [`EV_W-1:0] ev_mask_reg;
reg              fuse_s1_reg;
reg              fuse_s2_reg;
reg              fuse_s3_reg;
reg              fuse_reg;
reg              aw_held_reg;
reg  [`ADDR_W-1:0] aw_addr_reg;
reg              w_held_reg;
reg  [7:0]       w_data_reg;
reg              w_strb0_reg;

reg              irq_flag_next;
reg              irq_enable_next;
reg              guard_next;
reg  [2:0]       guard_cnt_next;
reg              rst_enable_next;
reg  [3:0]       sel_next;
reg  [`EV_W-1:0] ev_status_next;
reg  [`EV_W-1:0] ev_mask_next;
reg              gie_next;
reg              reset_fire;
reg              irq_fire;
reg  [31:0]      rd_value;
reg              rd_mapped;

wire             timeout;
wire             do_write;
wire             wr_hit;
wire             wr_mapped;
wire             wr_control;
wire             wr_core;
wire             wr_status;
wire             wr_mask;
wire             kick;
wire             rst_enable_eff;
wire             mode_reset_only;
wire             mode_irq_only;
wire             mode_combined;
wire             running;
wire [3:0]       sel_wr;
wire [7:0]       control_rd;

// ----------------------------------------
// Fuse synchroniser
// ----------------------------------------
// Strap may settle after reset; only agreeing samples are trusted
always @(posedge clk) begin
   if (rst) begin
      fuse_s1_reg <= 1'b0;
      fuse_s2_reg <= 1'b0;
      fuse_s3_reg <= 1'b0;
      fuse_reg    <= 1'b0;
   end else begin
      fuse_s1_reg <= always_on_fuse;
      fuse_s2_reg <= fuse_s1_reg;
      fuse_s3_reg <= fuse_s2_reg;
      if (fuse_s2_reg == fuse_s3_reg) begin
         fuse_reg <= fuse_s3_reg;
      end
   end
end

// ----------------------------------------
// Mode decode
// ----------------------------------------
assign rst_enable_eff  = rst_enable_reg | watchdog_reset_flag;
assign mode_reset_only = fuse_reg | (rst_enable_eff & ~irq_enable_reg);
assign mode_irq_only   = ~fuse_reg & ~rst_enable_eff & irq_enable_reg;
assign mode_combined   = ~fuse_reg & rst_enable_eff & irq_enable_reg;
assign running         = mode_reset_only | mode_irq_only | mode_combined;

// ----------------------------------------
// Bus write decode
// ----------------------------------------
assign do_write   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
assign wr_hit     = do_write & w_strb0_reg;
assign wr_mapped  = (aw_addr_reg == `ADDR_CONTROL) | (aw_addr_reg == `ADDR_CORE_CTRL) |
                    (aw_addr_reg == `ADDR_INT_STATUS) | (aw_addr_reg == `ADDR_INT_MASK);
assign wr_control = wr_hit & (aw_addr_reg == `ADDR_CONTROL);
assign wr_core    = wr_hit & (aw_addr_reg == `ADDR_CORE_CTRL);
assign wr_status  = wr_hit & (aw_addr_reg == `ADDR_INT_STATUS);
assign wr_mask    = wr_hit & (aw_addr_reg == `ADDR_INT_MASK);
assign kick       = wr_core & w_data_reg[`BIT_KICK];
assign sel_wr     = {w_data_reg[`BIT_SEL3], w_data_reg[`BIT_SEL2], w_data_reg[`BIT_SEL1], w_data_reg[`BIT_SEL0]};

assign control_rd = {irq_flag_reg, irq_enable_reg, sel_reg[3], guard_reg,
                     rst_enable_eff, sel_reg[2:0]};

// ----------------------------------------
// Time-out divider
// ----------------------------------------
period_divider #(
   .BASE_SHIFT (BASE_SHIFT)
) u_divider (
   .clk     (clk),
   .rst     (rst),
   .run     (running),
   .restart (kick | (sel_next != sel_reg)),
   .sel     (sel_reg),
   .timeout (timeout)
);

// ----------------------------------------
// Control next state
// ----------------------------------------
always @* begin
   irq_flag_next   = irq_flag_reg;
   irq_enable_next = irq_enable_reg;
   guard_next      = guard_reg;
   guard_cnt_next  = guard_cnt_reg;
   rst_enable_next = rst_enable_reg;
   sel_next        = sel_reg;
   gie_next        = global_irq_enable;
   reset_fire      = 1'b0;
   irq_fire        = 1'b0;

   // Guard self-clears; a fresh write restarts it
   if (guard_reg) begin
      if (guard_cnt_reg == `GUARD_LAST) begin
         guard_next = 1'b0;
      end else begin
         guard_cnt_next = guard_cnt_reg - 3'h1;
      end
   end

   if (wr_control) begin
      if (w_data_reg[`BIT_IRQ_FLAG]) begin
         irq_flag_next = 1'b0;
      end
      irq_enable_next = w_data_reg[`BIT_IRQ_ENABLE];
      if (w_data_reg[`BIT_RST_ENABLE]) begin
         rst_enable_next = 1'b1;
      end else if (guard_reg && !watchdog_reset_flag) begin
         rst_enable_next = 1'b0;
      end
      if (guard_reg) begin
         sel_next = sel_wr;
      end
      if (w_data_reg[`BIT_GUARD]) begin
         guard_next     = 1'b1;
         guard_cnt_next = `GUARD_CYCLES;
      end
   end

   if (vector_exec) begin
      irq_flag_next = 1'b0;
      // A same-cycle software re-arm is kept
      if (mode_combined && !(wr_control && w_data_reg[`BIT_IRQ_ENABLE])) begin
         irq_enable_next = 1'b0;
      end
   end

   if (timeout) begin
      if (mode_reset_only || (mode_combined && irq_flag_reg)) begin
         reset_fire = 1'b1;
      end else begin
         irq_flag_next = 1'b1;
         irq_fire      = 1'b1;
      end
   end

   if (wr_core) begin
      gie_next = w_data_reg[`BIT_GIE];
   end
   if (irq_taken) begin
      gie_next = 1'b0;
   end
   if (irq_return) begin
      gie_next = 1'b1;
   end
end

// ----------------------------------------
// Event status and mask
// ----------------------------------------
always @* begin
   ev_status_next = ev_status_reg;
   ev_mask_next   = ev_mask_reg;
   if (wr_status) begin
      ev_status_next = ev_status_reg & ~w_data_reg[`EV_W-1:0];
   end
   // Hardware set wins over a same-cycle clear
   ev_status_next[`EV_TIMEOUT_IRQ] = ev_status_next[`EV_TIMEOUT_IRQ] | irq_fire;
   ev_status_next[`EV_RESET_REQ]   = ev_status_next[`EV_RESET_REQ] | reset_fire;
   if (wr_mask) begin
      ev_mask_next = w_data_reg[`EV_W-1:0];
   end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
always @* begin
   rd_value  = 32'h0000_0000;
   rd_mapped = 1'b1;
   case (s_axi_araddr)
      `ADDR_CONTROL:    rd_value[7:0] = control_rd;
      `ADDR_CORE_CTRL:  rd_value[`BIT_RESET_FLAG:0] = {watchdog_reset_flag, fuse_reg, 1'b0, global_irq_enable};
      `ADDR_INT_STATUS: rd_value[`EV_W-1:0] = ev_status_reg;
      `ADDR_INT_MASK:   rd_value[`EV_W-1:0] = ev_mask_reg;
      default:          rd_mapped = 1'b0;
   endcase
end

// ----------------------------------------
// Registers
// ----------------------------------------
always @(posedge clk) begin
   if (rst) begin
      irq_flag_reg      <= 1'b0;
      irq_enable_reg    <= 1'b0;
      guard_reg         <= 1'b0;
      guard_cnt_reg     <= 3'h0;
      rst_enable_reg    <= 1'b0;
      sel_reg           <= `RST_SEL;
      ev_status_reg     <= `RST_EV;
      ev_mask_reg       <= `RST_EV;
      global_irq_enable <= 1'b0;
      wdt_irq_req       <= 1'b0;
      sys_reset_req     <= 1'b0;
      irq               <= 1'b0;
   end else begin
      irq_flag_reg      <= irq_flag_next;
      irq_enable_reg    <= irq_enable_next;
      guard_reg         <= guard_next;
      guard_cnt_reg     <= guard_cnt_next;
      rst_enable_reg    <= rst_enable_next;
      sel_reg           <= sel_next;
      ev_status_reg     <= ev_status_next;
      ev_mask_reg       <= ev_mask_next;
      global_irq_enable <= gie_next;
      wdt_irq_req       <= irq_flag_next & irq_enable_next & gie_next;
      sys_reset_req     <= reset_fire;
      irq               <= |(ev_status_next & ev_mask_next);
   end
end

// ----------------------------------------
// AXI4-Lite handshakes
// ----------------------------------------
// One write and one read in flight; ready drops until the response is taken
always @(posedge clk) begin
   if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `AXI_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_held_reg    <= 1'b0;
      w_data_reg    <= 8'h00;
      w_strb0_reg   <= 1'b0;
   end else begin
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg   <= 1'b1;
         aw_addr_reg   <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg   <= 1'b1;
         w_data_reg   <= s_axi_wdata[7:0];
         w_strb0_reg  <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end
      if (do_write) begin
         aw_held_reg  <= 1'b0;
         w_held_reg   <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? `AXI_OKAY : `AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid  <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_value;
         s_axi_rresp   <= rd_mapped ? `AXI_OKAY : `AXI_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
end

endmodule // watchdog_control_modes

// [dv/watchdog_control_modes_sva.sv]
`timescale 1ns/10ps
`include "watchdog_ctrl_regs.vh"
module wdt_ctrl_chk #(
   parameter BASE_SHIFT = 4           // Divider base, unused here
) (
   input wire        clk,               // Clock
   input wire        rst,               // Reset
   input wire        s_axi_awvalid,     // AW valid
   input wire        s_axi_awready,     // AW ready
   input wire        s_axi_wvalid,      // W valid
   input wire        s_axi_wready,      // W ready
   input wire        s_axi_bvalid,      // B valid
   input wire        s_axi_bready,      // B ready
   input wire        s_axi_arvalid,     // AR valid
   input wire        s_axi_arready,     // AR ready
   input wire [31:0] s_axi_rdata,       // Read data
   input wire        s_axi_rvalid,      // R valid
   input wire        s_axi_rready,      // R ready
   input wire        vector_exec,       // Vector pulse
   input wire        irq_taken,         // Entry pulse
   input wire        irq_return,        // Return pulse
   input wire        wdt_irq_req,       // Request to core
   input wire        sys_reset_req,     // Reset pulse
   input wire        global_irq_enable  // Global enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   // No write can execute while both readys are high
   sequence bus_idle;
      s_axi_awready && s_axi_wready;
   endsequence
   sequence core_entry;
      irq_taken && vector_exec && !irq_return;
   endsequence
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   chk_req_needs_gie: assert property (wdt_irq_req |-> global_irq_enable)
      else $error("request without global enable");
   chk_entry_clears: assert property (core_entry ##0 bus_idle |=> !global_irq_enable && !wdt_irq_req)
      else $error("entry did not drop request");
   chk_return_sets: assert property (irq_return |=> global_irq_enable)
      else $error("return did not set global enable");
   chk_req_holds: assert property (wdt_irq_req && !irq_taken && !vector_exec ##0 bus_idle |=> wdt_irq_req)
      else $error("request dropped without cause");
   chk_reset_single: assert property (sys_reset_req |=> !sys_reset_req)
      else $error("reset request longer than one cycle");
   chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   chk_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   chk_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response not held");
endmodule // wdt_ctrl_chk

bind watchdog_control_modes wdt_ctrl_chk #(.BASE_SHIFT(BASE_SHIFT)) u_chk (
   .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .vector_exec(vector_exec), .irq_taken(irq_taken), .irq_return(irq_return),
   .wdt_irq_req(wdt_irq_req), .sys_reset_req(sys_reset_req), .global_irq_enable(global_irq_enable));

// [dv/core_model.sv]
`timescale 1ns/10ps
module core_model (
   input  wire clk,          // Clock
   input  wire rst,          // Reset
   input  wire wdt_irq_req,  // Request from watchdog
   input  wire serve,        // Low holds requests off
   output reg  vector_exec,  // Vector pulse
   output reg  irq_taken,    // Entry pulse
   output reg  irq_return    // Return pulse
);
   reg [3:0] busy_reg;

   // Handler body lasts eight cycles, so entry never overlaps return
   always @(posedge clk) begin
      vector_exec <= 1'b0;
      irq_taken <= 1'b0;
      irq_return <= 1'b0;
      if (rst) begin
         busy_reg <= 4'h0;
      end else if (busy_reg != 4'h0) begin
         busy_reg <= busy_reg - 4'h1;
         irq_return <= (busy_reg == 4'h1);
      end else if (wdt_irq_req && serve) begin
         vector_exec <= 1'b1;
         irq_taken <= 1'b1;
         busy_reg <= 4'h8;
      end
   end
endmodule // core_model

// [dv/watchdog_control_modes_tb.sv]
`timescale 1ns/10ps
module watchdog_control_modes_tb;
   reg         clk, rst, awvalid, wvalid, bready, arvalid, rready, fuse, rflag, serve;
   reg  [3:0]  awaddr, araddr;
   reg  [31:0] wdata;
   reg  [1:0]  resp;
   wire        awready, wready, bvalid, arready, rvalid, vec, taken, ret, req, sreset, gie, irq;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   integer     mismatches, n_compared, cycles;
   bit         s;

   watchdog_control_modes #(.BASE_SHIFT(2)) i_dut (
      .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .always_on_fuse(fuse),
      .watchdog_reset_flag(rflag), .vector_exec(vec), .irq_taken(taken), .irq_return(ret),
      .wdt_irq_req(req), .sys_reset_req(sreset), .global_irq_enable(gie), .irq(irq));
   core_model i_core (.clk(clk), .rst(rst), .wdt_irq_req(req), .serve(serve),
      .vector_exec(vec), .irq_taken(taken), .irq_return(ret));

   always #12.5 clk = ~clk;

   // Ceiling well above the longest sequence, about 9000 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         mismatches = mismatches + 1;
         wrap_up;
      end
   end

   // ----------------------------------------
   // Bus and check helpers
   // ----------------------------------------
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // Entered just after an edge; returns just after the answer edge
   task wr(input [3:0] a, input [31:0] v);
      bit aw, w;
      begin
         aw = 0;
         w = 0;
         awaddr <= a;
         wdata <= v;
         awvalid <= 1;
         wvalid <= 1;
         while (!(aw && w)) begin
            @(posedge clk);
            if (awvalid && awready) begin aw = 1; awvalid <= 0; end
            if (wvalid && wready) begin w = 1; wvalid <= 0; end
         end
         bready <= 1;
         do @(posedge clk); while (bvalid !== 1'b1);
         resp = bresp;
         bready <= 0;
      end
   endtask
   task rc(input [3:0] a, input [31:0] e, input string nm);
      begin
         araddr <= a;
         arvalid <= 1;
         do @(posedge clk); while (arready !== 1'b1);
         arvalid <= 0;
         rready <= 1;
         do @(posedge clk); while (rvalid !== 1'b1);
         resp = rresp;
         rready <= 0;
         chk(nm, e, rdata);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Records whether the reset pulse (or the request) shows within n cycles
   task seen(input int n, input bit rsel);
      begin
         s = 0;
         repeat (n) begin
            @(posedge clk);
            if ((rsel ? sreset : req) === 1'b1) s = 1;
         end
      end
   endtask
   task guarded(input [31:0] v);
      begin
         wr(4'h0, 32'h0000_0010);
         wr(4'h0, v);
         wt(6);
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      begin
         rc(4'h0, 32'h0000_0000, "control");
         rc(4'h4, 32'h0000_0000, "core_ctrl");
         chk("read resp", 0, resp);
      end
   endtask
   task t_guard;
      begin
         wr(4'h0, 32'h0000_0010);
         chk("write resp", 0, resp);
         rc(4'h0, 32'h0000_0010, "guard set");
         wt(6);
         rc(4'h0, 32'h0000_0000, "guard expired");
         wr(4'h0, 32'h0000_0020);
         wt(6);
         rc(4'h0, 32'h0000_0000, "unguarded sel");
         guarded(32'h0000_0020);
         rc(4'h0, 32'h0000_0020, "guarded sel");
         rc(4'h8, 32'h0000_0000, "stopped events");
      end
   endtask
   task t_reset_mode;
      begin
         wr(4'h0, 32'h0000_0028);
         seen(1100, 1);
         chk("reset pulse", 1, s);
         rc(4'h0, 32'h0000_0028, "no flag");
         wr(4'h0, 32'h0000_0020);
         wt(6);
         rc(4'h0, 32'h0000_0028, "unguarded clear");
         guarded(32'h0000_0020);
         rc(4'h0, 32'h0000_0020, "guarded clear");
      end
   endtask
   task t_reset_flag;
      begin
         rflag <= 1;
         wt(2);
         rc(4'h0, 32'h0000_0028, "forced enable");
         wr(4'h0, 32'h0000_0028);
         guarded(32'h0000_0020);
         rflag <= 0;
         wt(2);
         rc(4'h0, 32'h0000_0028, "blocked clear");
         guarded(32'h0000_0020);
         rc(4'h0, 32'h0000_0020, "clear after flag");
      end
   endtask
   task t_irq_mode;
      begin
         wr(4'h0, 32'h0000_0060);
         wt(1030);
         rc(4'h0, 32'h0000_00e0, "flag set");
         chk("request without gie", 0, req);
         wr(4'h0, 32'h0000_0060);
         rc(4'h0, 32'h0000_00e0, "zero write");
         wr(4'h0, 32'h0000_00e0);
         rc(4'h0, 32'h0000_0060, "one write");
         wt(1030);
         serve <= 1;
         wr(4'h4, 32'h0000_0001);
         seen(20, 0);
         chk("request with gie", 1, s);
         chk("gie after return", 1, gie);
         rc(4'h0, 32'h0000_0060, "vector clear");
      end
   endtask
   task t_combined;
      begin
         wr(4'h0, 32'h0000_0068);
         wt(1050);
         rc(4'h0, 32'h0000_0028, "fallback");
         serve <= 0;
         wr(4'h0, 32'h0000_0068);
         seen(2100, 1);
         chk("unserviced reset", 1, s);
         rc(4'h0, 32'h0000_00e8, "flag kept");
      end
   endtask
   task t_fuse;
      begin
         guarded(32'h0000_00a0);
         rc(4'h0, 32'h0000_0020, "stopped");
         fuse <= 1;
         wt(6);
         rc(4'h4, 32'h0000_0005, "fuse read");
         // Kicks well inside the period keep the reset away
         repeat (2) begin
            seen(600, 1);
            chk("kicked reset", 0, s);
            wr(4'h4, 32'h0000_0003);
         end
         seen(1100, 1);
         chk("fuse reset", 1, s);
         fuse <= 0;
         wt(6);
      end
   endtask
   task t_events;
      begin
         rc(4'h8, 32'h0000_0003, "status");
         chk("masked irq", 0, irq);
         wr(4'hc, 32'h0000_0002);
         wt(2);
         chk("unmasked irq", 1, irq);
         wr(4'h8, 32'h0000_0002);
         wt(2);
         chk("cleared irq", 0, irq);
         rc(4'h8, 32'h0000_0001, "status left");
         rc(4'h2, 32'h0000_0000, "unmapped");
         chk("unmapped rresp", 2, resp);
         wr(4'h2, 32'h0000_00ff);
         chk("unmapped bresp", 2, resp);
         rc(4'h8, 32'h0000_0001, "status kept");
      end
   endtask

   task wrap_up;
      begin
         $display("Compared %0d, mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   initial begin
      {clk, awvalid, wvalid, bready, arvalid, rready, fuse, rflag, serve} = 0;
      {awaddr, araddr, wdata} = 0;
      {mismatches, n_compared, cycles} = 0;
      rst = 1;
      repeat (10) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      t_reset;
      t_guard;
      t_reset_mode;
      t_reset_flag;
      t_irq_mode;
      t_combined;
      t_fuse;
      t_events;
      wrap_up;
   end
endmodule // watchdog_control_modes_tb
